// ==== psm_monitor.sv ====
// Power source monitor: APB register bank, input debounce, status, interrupt and wake clock.
//
// Operation
// R1 - Bit 6 enables supply comparator
// R2 - Supply debounce: none, 10us, 30us, 60us
// R3 - Threshold 0000 no limit, 1xxx not applicable
// R4 - Adapter debounce 81us, 10, 20, 30 ms
// R5 - Adapter events on rise, fall or both
// R6 - Low battery debounce 4-128 slow periods
// R7 - Second battery detection only when enabled
// R8 - First battery detection only when enabled
// R9 - Adapter comparator enable bit, reset one
// R10 - Second battery low flag, read only
// R11 - First battery low flag, read only
// R12 - Adapter present flag, read only
// R13 - Wake clock runs only when enabled
// R14 - Flag changes after full stable debounce
// R15 - Reserved RW kept, reserved RO zero
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Debounce cell
// ****************************************************************
module psm_debounce (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Raw level and hold time in cycles
	input  wire logic        raw,
	input  wire logic [31:0] target,
	// Debounced level and run counter
	output logic             level_q,
	output logic [31:0]      cnt_q
);
	logic prev_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= raw;
		end
	end

	// R14 - restart on toggle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_q <= 1'b0;
			cnt_q   <= 32'h0000_0000;
		end else if (raw != prev_q || raw == level_q) begin
			cnt_q <= 32'h0000_0000;
		end else if (cnt_q >= target) begin
			level_q <= raw;
			cnt_q   <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end
endmodule

// ****************************************************************
// Top level
// ****************************************************************
module psm_monitor #(
	parameter int unsigned SUP_DB3_CYC = 32'((psm_pkg::T_SUP_DB3_NS + psm_pkg::CLK_NS - 1) / psm_pkg::CLK_NS),
	parameter int unsigned ADP_DB0_CYC = 32'((psm_pkg::T_ADP_DB0_NS + psm_pkg::CLK_NS - 1) / psm_pkg::CLK_NS),
	parameter int unsigned ADP_DB1_CYC = 32'((psm_pkg::T_ADP_DB1_NS + psm_pkg::CLK_NS - 1) / psm_pkg::CLK_NS),
	parameter int unsigned ADP_DB2_CYC = 32'((psm_pkg::T_ADP_DB2_NS + psm_pkg::CLK_NS - 1) / psm_pkg::CLK_NS),
	parameter int unsigned ADP_DB3_CYC = 32'((psm_pkg::T_ADP_DB3_NS + psm_pkg::CLK_NS - 1) / psm_pkg::CLK_NS),
	parameter int unsigned LB_DB0_CYC  = psm_pkg::LB_N0 * psm_pkg::SLOW_CYC,
	parameter int unsigned LB_DB1_CYC  = psm_pkg::LB_N1 * psm_pkg::SLOW_CYC,
	parameter int unsigned LB_DB2_CYC  = psm_pkg::LB_N2 * psm_pkg::SLOW_CYC,
	parameter int unsigned LB_DB3_CYC  = psm_pkg::LB_N3 * psm_pkg::SLOW_CYC,
	parameter int unsigned WAKE_HALF_CYC = 32'(psm_pkg::T_WAKE_NS / (2 * psm_pkg::CLK_NS))
) (
	// Clock and reset
	input  wire logic                        CORE_CLK,
	input  wire logic                        ARST_N,
	// APB slave
	input  wire logic                        PSEL,
	input  wire logic                        PENABLE,
	input  wire logic                        PWRITE,
	input  wire logic [psm_pkg::ADDR_W-1:0]  PADDR,
	input  wire logic [31:0]                 PWDATA,
	input  wire logic [3:0]                  PSTRB,
	output logic [31:0]                      PRDATA,
	output logic                             PREADY,
	output logic                             PSLVERR,
	// Comparator results from the sense pins
	input  wire logic                        SUPPLY_SENSE_CMP,
	input  wire logic                        ADAPTER_GOOD,
	input  wire logic                        BATT1_LOW_CMP,
	input  wire logic                        BATT2_LOW_CMP,
	// Comparator controls and the debounced supply low level
	output logic                             SUPPLY_CMP_EN,
	output logic [3:0]                       SUPPLY_FALL_THRESHOLD,
	output logic                             SUPPLY_LOW,
	output logic                             ADAPTER_CMP_EN,
	output logic                             BATT1_DET_EN,
	output logic                             BATT2_DET_EN,
	// Wake clock and interrupt
	output logic                             WAKE_CLK,
	output logic                             IRQ
);
	// ****************************************************************
	// Registers and synchronisers
	// ****************************************************************
	psm_pkg::psm_sup_limit_t sup_q;
	psm_pkg::psm_adp_cfg_t   adp_q;
	psm_pkg::psm_lb_cfg_t    lb_q;
	logic [7:0]  wake_q;
	logic [7:0]  stat_q;
	logic [7:0]  stat_d;
	logic [7:0]  int_q;
	logic [7:0]  mask_q;
	logic [7:0]  evt;
	logic [3:0]  meta_q;
	logic [3:0]  sync_q;
	logic [7:0]  idx;
	logic        hit;
	logic [7:0]  rd_byte;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic [31:0] sup_tgt;
	logic [31:0] adp_tgt;
	logic [31:0] lb_tgt;
	logic        sup_lvl;
	logic        adp_lvl;
	logic        b1_lvl;
	logic        b2_lvl;
	logic [31:0] sup_cnt;
	logic [31:0] adp_cnt;
	logic [31:0] b1_cnt;
	logic [31:0] b2_cnt;
	logic [31:0] wake_cnt_q;

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
		end else begin
			meta_q <= {BATT2_LOW_CMP, BATT1_LOW_CMP, ADAPTER_GOOD, SUPPLY_SENSE_CMP};
			sync_q <= meta_q;
		end
	end

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign idx   = PADDR[9:2];
	assign wbyte = PWDATA[7:0];
	assign hit   = (PADDR[1:0] == 2'b00) && (PADDR[psm_pkg::ADDR_W-1:10] == 2'b00) &&
	               (idx == psm_pkg::IDX_SUP_LIMIT || idx == psm_pkg::IDX_ADP_CFG ||
	                idx == psm_pkg::IDX_LB_CFG || idx == psm_pkg::IDX_STATUS ||
	                idx == psm_pkg::IDX_WAKE || idx == psm_pkg::IDX_INT_STATUS ||
	                idx == psm_pkg::IDX_INT_MASK);
	assign wr_en = PSEL && PENABLE && PREADY && PWRITE && hit && PSTRB[0];

	always_comb begin
		case (idx)
			psm_pkg::IDX_SUP_LIMIT:  rd_byte = sup_q;
			psm_pkg::IDX_ADP_CFG:    rd_byte = adp_q;
			psm_pkg::IDX_LB_CFG:     rd_byte = lb_q;
			psm_pkg::IDX_STATUS:     rd_byte = stat_q;
			psm_pkg::IDX_WAKE:       rd_byte = wake_q;
			psm_pkg::IDX_INT_STATUS: rd_byte = int_q;
			psm_pkg::IDX_INT_MASK:   rd_byte = mask_q;
			default:                 rd_byte = 8'h00;
		endcase
	end

	// One wait state: the answer is registered on the first access edge.
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end else if (PSEL && PENABLE && !PREADY) begin
			PREADY  <= 1'b1;
			PSLVERR <= !hit;
			PRDATA  <= {24'h00_0000, hit ? rd_byte : 8'h00};
		end else begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	// R15 - reserved writable bits kept
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sup_q  <= psm_pkg::RST_SUP_LIMIT;
			adp_q  <= psm_pkg::RST_ADP_CFG;
			lb_q   <= psm_pkg::RST_LB_CFG;
			wake_q <= psm_pkg::RST_WAKE;
			mask_q <= psm_pkg::RST_INT;
		end else if (wr_en) begin
			case (idx)
				psm_pkg::IDX_SUP_LIMIT: sup_q  <= wbyte;
				psm_pkg::IDX_ADP_CFG:   adp_q  <= wbyte;
				psm_pkg::IDX_LB_CFG:    lb_q   <= wbyte;
				psm_pkg::IDX_WAKE:      wake_q <= wbyte;
				psm_pkg::IDX_INT_MASK:  mask_q <= wbyte;
				default:                mask_q <= mask_q;
			endcase
		end
	end

	// ****************************************************************
	// Debounce time selection
	// ****************************************************************
	always_comb begin
		// R2 - supply debounce select
		case (sup_q.db_sel)
			2'b00:   sup_tgt = 32'h0000_0000;
			2'b01:   sup_tgt = psm_pkg::SUP_DB1_CYC;
			2'b10:   sup_tgt = psm_pkg::SLOW_CYC;
			default: sup_tgt = 32'(SUP_DB3_CYC);
		endcase
		// R4 - adapter debounce select
		case (adp_q.db_sel)
			2'b00:   adp_tgt = 32'(ADP_DB0_CYC);
			2'b01:   adp_tgt = 32'(ADP_DB1_CYC);
			2'b10:   adp_tgt = 32'(ADP_DB2_CYC);
			default: adp_tgt = 32'(ADP_DB3_CYC);
		endcase
		// R6 - low battery debounce select
		case (lb_q.db_sel)
			2'b00:   lb_tgt = 32'(LB_DB0_CYC);
			2'b01:   lb_tgt = 32'(LB_DB1_CYC);
			2'b10:   lb_tgt = 32'(LB_DB2_CYC);
			default: lb_tgt = 32'(LB_DB3_CYC);
		endcase
	end

	// A disabled comparator feeds a low level: supply and adapter flags fall after the debounce time, battery flags on the next edge.
	psm_debounce u_db_sup (
		.clk     (CORE_CLK),
		.arst_n  (ARST_N),
		.raw     (sync_q[0] && sup_q.cmp_en),
		.target  (sup_tgt),
		.level_q (sup_lvl),
		.cnt_q   (sup_cnt)
	);
	psm_debounce u_db_adp (
		.clk     (CORE_CLK),
		.arst_n  (ARST_N),
		.raw     (sync_q[1] && lb_q.adapter_comparator_enable),
		.target  (adp_tgt),
		.level_q (adp_lvl),
		.cnt_q   (adp_cnt)
	);
	psm_debounce u_db_b1 (
		.clk     (CORE_CLK),
		.arst_n  (ARST_N),
		.raw     (sync_q[2] && lb_q.b1_en),
		.target  (lb_tgt),
		.level_q (b1_lvl),
		.cnt_q   (b1_cnt)
	);
	psm_debounce u_db_b2 (
		.clk     (CORE_CLK),
		.arst_n  (ARST_N),
		.raw     (sync_q[3] && lb_q.b2_en),
		.target  (lb_tgt),
		.level_q (b2_lvl),
		.cnt_q   (b2_cnt)
	);

	// ****************************************************************
	// Status and events
	// ****************************************************************
	always_comb begin
		stat_d = psm_pkg::RST_STATUS;
		// R12 - adapter present flag
		stat_d[psm_pkg::BIT_ADP] = adp_lvl;
		// R8 R11 - first battery flag
		stat_d[psm_pkg::BIT_B1] = b1_lvl && lb_q.b1_en;
		// R7 R10 - second battery flag
		stat_d[psm_pkg::BIT_B2] = b2_lvl && lb_q.b2_en;
		evt = 8'h00;
		evt[psm_pkg::BIT_SUP_EVT] = sup_lvl && !SUPPLY_LOW;
		// R5 - adapter edge mode
		evt[psm_pkg::BIT_ADP] = (adp_lvl && !stat_q[psm_pkg::BIT_ADP] && adp_q.edge_mode[0]) ||
		                        (!adp_lvl && stat_q[psm_pkg::BIT_ADP] && adp_q.edge_mode[1]);
		evt[psm_pkg::BIT_B1] = stat_d[psm_pkg::BIT_B1] != stat_q[psm_pkg::BIT_B1];
		evt[psm_pkg::BIT_B2] = stat_d[psm_pkg::BIT_B2] != stat_q[psm_pkg::BIT_B2];
	end

	// R15 - reserved status bits zero
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			stat_q <= psm_pkg::RST_STATUS;
		end else begin
			stat_q <= stat_d;
		end
	end

	// A new event wins over a write-one-to-clear in the same cycle.
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			int_q <= psm_pkg::RST_INT;
		end else if (wr_en && idx == psm_pkg::IDX_INT_STATUS) begin
			int_q <= (int_q & ~wbyte) | evt;
		end else begin
			int_q <= int_q | evt;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(int_q & mask_q);
		end
	end

	// ****************************************************************
	// Comparator control outputs and supply low flag
	// ****************************************************************
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			SUPPLY_CMP_EN         <= 1'b0;
			SUPPLY_FALL_THRESHOLD <= psm_pkg::RST_SUP_LIMIT[3:0];
			SUPPLY_LOW            <= 1'b0;
			ADAPTER_CMP_EN        <= 1'b0;
			BATT1_DET_EN          <= 1'b0;
			BATT2_DET_EN          <= 1'b0;
		end else begin
			// R1 - supply comparator enable
			SUPPLY_CMP_EN <= sup_q.cmp_en;
			// R3 - codes 1xxx give no limit
			SUPPLY_FALL_THRESHOLD <= sup_q.thr[3] ? psm_pkg::THR_NO_LIMIT : sup_q.thr;
			SUPPLY_LOW <= sup_lvl;
			// R9 - adapter comparator enable
			ADAPTER_CMP_EN <= lb_q.adapter_comparator_enable;
			BATT1_DET_EN <= lb_q.b1_en;
			BATT2_DET_EN <= lb_q.b2_en;
		end
	end

	// ****************************************************************
	// Wake clock
	// ****************************************************************
	// R13 - gated one hertz clock
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wake_cnt_q <= 32'h0000_0000;
			WAKE_CLK   <= 1'b0;
		end else if (!wake_q[psm_pkg::BIT_WAKE_EN]) begin
			wake_cnt_q <= 32'h0000_0000;
			WAKE_CLK   <= 1'b0;
		end else if (wake_cnt_q >= 32'(WAKE_HALF_CYC) - 32'h0000_0001) begin
			wake_cnt_q <= 32'h0000_0000;
			WAKE_CLK   <= !WAKE_CLK;
		end else begin
			wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	property p_sup_en;
		sup_q.cmp_en |=> SUPPLY_CMP_EN;
	endproperty
	a_sup_en: assert property (p_sup_en) else $error("supply comparator enable lost"); // R1

	property p_sup_nodb;
		(sup_q.db_sel == 2'b00) && !sup_lvl && sup_q.cmp_en && sync_q[0] && $past(sync_q[0])
			&& $stable(sup_q) |=> sup_lvl;
	endproperty
	a_sup_nodb: assert property (p_sup_nodb) else $error("supply flag not immediate"); // R2

	property p_thr;
		sup_q.thr[3] |=> SUPPLY_FALL_THRESHOLD == psm_pkg::THR_NO_LIMIT;
	endproperty
	a_thr: assert property (p_thr) else $error("threshold code 1xxx not blocked"); // R3

	property p_adp_db;
		$changed(adp_lvl) |-> $past(adp_cnt) >= $past(adp_tgt);
	endproperty
	a_adp_db: assert property (p_adp_db) else $error("adapter flag changed early"); // R4

	property p_edge;
		(adp_q.edge_mode == psm_pkg::EDGE_FALL) && !int_q[psm_pkg::BIT_ADP] && adp_lvl
			&& !stat_q[psm_pkg::BIT_ADP] |=> !int_q[psm_pkg::BIT_ADP];
	endproperty
	a_edge: assert property (p_edge) else $error("rising edge flagged in fall mode"); // R5

	property p_lb_db;
		$changed(b1_lvl) |-> $past(b1_cnt) >= $past(lb_tgt);
	endproperty
	a_lb_db: assert property (p_lb_db) else $error("battery flag changed early"); // R6

	property p_b2_off;
		!lb_q.b2_en |=> !stat_q[psm_pkg::BIT_B2];
	endproperty
	a_b2_off: assert property (p_b2_off) else $error("battery two flag while disabled"); // R7

	property p_b1_off;
		!lb_q.b1_en |=> !stat_q[psm_pkg::BIT_B1];
	endproperty
	a_b1_off: assert property (p_b1_off) else $error("battery one flag while disabled"); // R8

	property p_acin;
		!lb_q.adapter_comparator_enable |=> !ADAPTER_CMP_EN;
	endproperty
	a_acin: assert property (p_acin) else $error("adapter comparator enable stuck"); // R9

	property p_flags;
		##1 stat_q[psm_pkg::BIT_ADP] == $past(adp_lvl) && stat_q[psm_pkg::BIT_B2] == $past(b2_lvl && lb_q.b2_en);
	endproperty
	a_flags: assert property (p_flags) else $error("status flags do not follow"); // R10 R12

	property p_wake;
		!wake_q[psm_pkg::BIT_WAKE_EN] |=> !WAKE_CLK;
	endproperty
	a_wake: assert property (p_wake) else $error("wake clock runs while off"); // R13

	property p_restart;
		(u_db_adp.raw != u_db_adp.prev_q) |=> adp_cnt == 32'h0000_0000;
	endproperty
	a_restart: assert property (p_restart) else $error("debounce not restarted"); // R14

	property p_rsv;
		PREADY && !PSLVERR && $past(idx) == psm_pkg::IDX_STATUS |-> PRDATA[7] == 1'b0 && PRDATA[3:0] == 4'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits nonzero"); // R15

	c_adp_in:  cover property ($rose(stat_q[psm_pkg::BIT_ADP]));
	c_b1_low:  cover property ($rose(stat_q[psm_pkg::BIT_B1]));
	c_irq:     cover property ($rose(IRQ));
	c_wake:    cover property ($rose(WAKE_CLK));
endmodule

`default_nettype wire

// ==== psm_monitor_tb.sv ====
// Self-checking testbench for the power source monitor register bank.
`timescale 1ns/1ps
`default_nettype none

module psm_monitor_tb;
	typedef struct packed {logic rd; logic err; logic [31:0] data;} psm_exp_t;
	logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb, lvl, cmp, thr;
	logic        sup_en, sup_low, adp_en, b1_en, b2_en, wake_clk, irq;
	logic [7:0]  d;
	int          num_errors, samples_checked, t, n;
	psm_exp_t    exp_q[$];
	psm_exp_t    e;

	psm_monitor #(.ADP_DB0_CYC(40), .ADP_DB3_CYC(100), .LB_DB0_CYC(40), .LB_DB3_CYC(100),
		.WAKE_HALF_CYC(8)) u_psm_monitor (
		.CORE_CLK(core_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SUPPLY_SENSE_CMP(cmp[3]), .ADAPTER_GOOD(cmp[0]), .BATT1_LOW_CMP(cmp[1]), .BATT2_LOW_CMP(cmp[2]),
		.SUPPLY_CMP_EN(sup_en), .SUPPLY_FALL_THRESHOLD(thr), .SUPPLY_LOW(sup_low), .ADAPTER_CMP_EN(adp_en),
		.BATT1_DET_EN(b1_en), .BATT2_DET_EN(b2_en), .WAKE_CLK(wake_clk), .IRQ(irq));

	psm_sense_model u_psm_sense_model (.clk(core_clk), .lvl(lvl), .en({sup_en, b2_en, b1_en, adp_en}), .cmp(cmp));

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	// One APB transfer; the expected answer is queued for the watching process.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd, input logic [31:0] x, input logic er);
		int k;
		exp_q.push_back('{!w, er, x});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0000_00, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			num_errors++;
			report_and_stop();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd, input logic er);
		apb(1'b1, {2'b00, idx, 2'b00}, wd, 32'h0000_0000, er);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic er);
		apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, {24'h0000_00, x}, er);
	endtask

	task automatic edges(output int c);
		logic p;
		c = 0;
		p = wake_clk;
		repeat (64) begin
			@(posedge core_clk);
			if (wake_clk === 1'b1 && p === 1'b0) c++;
			p = wake_clk;
		end
	endtask

	// ****************************************************************
	// Answer watcher
	// ****************************************************************
	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("[FAIL] %0t seen %h expected none", $time, prdata);
			end else begin
				e = exp_q.pop_front();
				check({31'h0000_0000, pslverr}, {31'h0000_0000, e.err});
				if (e.rd) check(prdata, e.data);
			end
		end
	end

	initial begin
		#1_000_000;
		num_errors++;
		report_and_stop();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		lvl = 4'h0;
		num_errors = 0;
		samples_checked = 0;
		void'($urandom(73290));
		cyc(3);
		arst_n <= 1'b1;
		cyc(2);
		rd(psm_pkg::IDX_SUP_LIMIT, psm_pkg::RST_SUP_LIMIT, 1'b0);
		rd(psm_pkg::IDX_ADP_CFG, psm_pkg::RST_ADP_CFG, 1'b0);
		rd(psm_pkg::IDX_LB_CFG, psm_pkg::RST_LB_CFG, 1'b0);
		rd(psm_pkg::IDX_STATUS, psm_pkg::RST_STATUS, 1'b0);
		rd(psm_pkg::IDX_WAKE, psm_pkg::RST_WAKE, 1'b0);
		check({29'h0000_0000, adp_en, b1_en, b2_en}, 32'h0000_0007);
		check({28'h0000_000, thr}, 32'h0000_0005);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			d = (8'($urandom) & 8'hF0) | 8'(c);
			wr(psm_pkg::IDX_SUP_LIMIT, d, 1'b0);
			cyc(2);
			check({28'h0000_000, thr}, c[3] ? 32'h0000_0000 : 32'(c));
			check({31'h0000_0000, sup_en}, {31'h0000_0000, d[6]});
			rd(psm_pkg::IDX_SUP_LIMIT, d, 1'b0);
		end
		wr(psm_pkg::IDX_SUP_LIMIT, 8'h05, 1'b0);
		d = 8'($urandom);
		wr(psm_pkg::IDX_ADP_CFG, d, 1'b0);
		rd(psm_pkg::IDX_ADP_CFG, d, 1'b0);
		d = 8'($urandom);
		wr(psm_pkg::IDX_LB_CFG, d, 1'b0);
		rd(psm_pkg::IDX_LB_CFG, d, 1'b0);
		check({29'h0000_0000, b2_en, b1_en, adp_en}, {29'h0000_0000, d[5:3]});
		wr(psm_pkg::IDX_LB_CFG, 8'hF8, 1'b0);
		wr(psm_pkg::IDX_STATUS, 8'hFF, 1'b0);
		rd(psm_pkg::IDX_STATUS, 8'h00, 1'b0);
		wr(8'h10, 8'hAA, 1'b1);
		rd(8'h10, 8'h00, 1'b1);
		apb(1'b0, 12'h1A5, 8'h00, 32'h0000_0000, 1'b1);
		pstrb <= 4'hE;
		wr(psm_pkg::IDX_WAKE, 8'hFF, 1'b0);
		pstrb <= 4'hF;
		rd(psm_pkg::IDX_WAKE, psm_pkg::RST_WAKE, 1'b0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			t = i[1] ? 100 : 40;
			wr(psm_pkg::IDX_ADP_CFG, 8'(i[1] ? 12 + i : i), 1'b0);
			wr(psm_pkg::IDX_INT_STATUS, 8'hFF, 1'b0);
			lvl[0] <= 1'b1;
			cyc(t / 2);
			lvl[0] <= 1'b0;
			cyc(2);
			lvl[0] <= 1'b1;
			cyc(t - 8);
			rd(psm_pkg::IDX_STATUS, 8'h00, 1'b0);
			cyc(t);
			rd(psm_pkg::IDX_STATUS, 8'h10, 1'b0);
			rd(psm_pkg::IDX_INT_STATUS, {3'b000, i[0], 4'h0}, 1'b0);
			wr(psm_pkg::IDX_INT_STATUS, 8'h10, 1'b0);
			lvl[0] <= 1'b0;
			cyc(t + 10);
			rd(psm_pkg::IDX_STATUS, 8'h00, 1'b0);
			rd(psm_pkg::IDX_INT_STATUS, {3'b000, i[1], 4'h0}, 1'b0);
		end
		$display("test adapter done");
		wr(psm_pkg::IDX_INT_STATUS, 8'hFF, 1'b0);
		lvl[2:1] <= 2'b11;
		cyc(110);
		rd(psm_pkg::IDX_STATUS, 8'h60, 1'b0);
		check({31'h0000_0000, irq}, 32'h0000_0000);
		wr(psm_pkg::IDX_INT_MASK, 8'h60, 1'b0);
		cyc(3);
		check({31'h0000_0000, irq}, 32'h0000_0001);
		wr(psm_pkg::IDX_INT_STATUS, 8'h60, 1'b0);
		cyc(3);
		check({31'h0000_0000, irq}, 32'h0000_0000);
		rd(psm_pkg::IDX_INT_STATUS, 8'h00, 1'b0);
		wr(psm_pkg::IDX_LB_CFG, 8'hD8, 1'b0);
		rd(psm_pkg::IDX_STATUS, 8'h20, 1'b0);
		wr(psm_pkg::IDX_LB_CFG, 8'hC8, 1'b0);
		rd(psm_pkg::IDX_STATUS, 8'h00, 1'b0);
		cyc(120);
		wr(psm_pkg::IDX_LB_CFG, 8'h38, 1'b0);
		cyc(20);
		rd(psm_pkg::IDX_STATUS, 8'h00, 1'b0);
		cyc(30);
		rd(psm_pkg::IDX_STATUS, 8'h60, 1'b0);
		lvl[2:1] <= 2'b00;
		wr(psm_pkg::IDX_LB_CFG, 8'h30, 1'b0);
		cyc(1);
		check({31'h0000_0000, adp_en}, 32'h0000_0000);
		lvl[0] <= 1'b1;
		cyc(120);
		rd(psm_pkg::IDX_STATUS, 8'h00, 1'b0);
		wr(psm_pkg::IDX_LB_CFG, 8'hF8, 1'b0);
		cyc(120);
		rd(psm_pkg::IDX_STATUS, 8'h10, 1'b0);
		lvl[0] <= 1'b0;
		$display("test battery done");
		wr(psm_pkg::IDX_SUP_LIMIT, 8'h45, 1'b0);
		cyc(1);
		check({31'h0000_0000, sup_en}, 32'h0000_0001);
		lvl[3] <= 1'b1;
		cyc(10);
		check({31'h0000_0000, sup_low}, 32'h0000_0001);
		wr(psm_pkg::IDX_SUP_LIMIT, 8'h55, 1'b0);
		lvl[3] <= 1'b0;
		cyc(900);
		check({31'h0000_0000, sup_low}, 32'h0000_0001);
		cyc(150);
		check({31'h0000_0000, sup_low}, 32'h0000_0000);
		wr(psm_pkg::IDX_SUP_LIMIT, 8'h75, 1'b0);
		lvl[3] <= 1'b1;
		cyc(5900);
		check({31'h0000_0000, sup_low}, 32'h0000_0000);
		cyc(150);
		check({31'h0000_0000, sup_low}, 32'h0000_0001);
		wr(psm_pkg::IDX_SUP_LIMIT, 8'h65, 1'b0);
		lvl[3] <= 1'b0;
		cyc(2900);
		check({31'h0000_0000, sup_low}, 32'h0000_0001);
		cyc(150);
		check({31'h0000_0000, sup_low}, 32'h0000_0000);
		wr(psm_pkg::IDX_SUP_LIMIT, 8'h05, 1'b0);
		cyc(1);
		check({31'h0000_0000, sup_en}, 32'h0000_0000);
		$display("test supply done");
		d = {7'($urandom), 1'b1};
		wr(psm_pkg::IDX_WAKE, d, 1'b0);
		rd(psm_pkg::IDX_WAKE, d, 1'b0);
		cyc(20);
		edges(n);
		check(32'(n), 32'h0000_0004);
		wr(psm_pkg::IDX_WAKE, 8'h00, 1'b0);
		cyc(4);
		edges(n);
		check(32'(n), 32'h0000_0000);
		check({31'h0000_0000, wake_clk}, 32'h0000_0000);
		$display("test wake done");
		report_and_stop();
	end
endmodule

`default_nettype wire

// ==== psm_pkg.sv ====
// Shared constants, register layouts and timing figures for the power source monitor registers.
package psm_pkg;

	// ****************************************************************
	// Register indices, reset values and field positions
	// ****************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam logic [7:0] IDX_SUP_LIMIT = 8'h51;
	localparam logic [7:0] IDX_ADP_CFG = 8'h69;
	localparam logic [7:0] IDX_LB_CFG = 8'h6A;
	localparam logic [7:0] IDX_STATUS = 8'h6F;
	localparam logic [7:0] IDX_WAKE = 8'hD0;
	localparam logic [7:0] IDX_INT_STATUS = 8'hE0;
	localparam logic [7:0] IDX_INT_MASK = 8'hE1;

	localparam logic [7:0] RST_SUP_LIMIT = 8'h05;
	localparam logic [7:0] RST_ADP_CFG = 8'h0F;
	localparam logic [7:0] RST_LB_CFG = 8'hF8;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_WAKE = 8'h00;
	localparam logic [7:0] RST_INT = 8'h00;

	localparam int unsigned BIT_SUP_EVT = 0;
	localparam int unsigned BIT_ADP = 4;
	localparam int unsigned BIT_B1 = 5;
	localparam int unsigned BIT_B2 = 6;
	localparam int unsigned BIT_WAKE_EN = 0;
	localparam logic [3:0] THR_NO_LIMIT = 4'h0;

	// ****************************************************************
	// Timing figures and derived cycle counts
	// ****************************************************************
	localparam longint unsigned CLK_NS = 10;
	localparam longint unsigned T_SUP_DB1_NS = 10_000;
	localparam longint unsigned T_SLOW_NS = 30_000;
	localparam longint unsigned T_SUP_DB3_NS = 60_000;
	localparam longint unsigned T_ADP_DB0_NS = 81_000;
	localparam longint unsigned T_ADP_DB1_NS = 10_000_000;
	localparam longint unsigned T_ADP_DB2_NS = 20_000_000;
	localparam longint unsigned T_ADP_DB3_NS = 30_000_000;
	localparam longint unsigned T_WAKE_NS = 1_000_000_000;
	localparam int unsigned LB_N0 = 4;
	localparam int unsigned LB_N1 = 32;
	localparam int unsigned LB_N2 = 64;
	localparam int unsigned LB_N3 = 128;
	localparam logic [31:0] SUP_DB1_CYC = 32'((T_SUP_DB1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [31:0] SLOW_CYC = 32'((T_SLOW_NS + CLK_NS - 1) / CLK_NS);

	// ****************************************************************
	// Register layouts
	// ****************************************************************
	typedef struct packed {
		logic       rsv;
		logic       cmp_en;
		logic [1:0] db_sel;
		logic [3:0] thr;
	} psm_sup_limit_t;

	typedef struct packed {
		logic [3:0] rsv;
		logic [1:0] db_sel;
		logic [1:0] edge_mode;
	} psm_adp_cfg_t;

	typedef struct packed {
		logic [1:0] db_sel;
		logic       b2_en;
		logic       b1_en;
		logic       adapter_comparator_enable;
		logic [2:0] rsv;
	} psm_lb_cfg_t;

	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_FALL = 2'b10;
	localparam logic [1:0] EDGE_BOTH = 2'b11;

endpackage

// ==== psm_sense_model.sv ====
// Behavioural model of the sense comparators that feed the power source monitor.
`timescale 1ns/1ps
`default_nettype none

module psm_sense_model (
	// Clock
	input  wire logic       clk,
	// Requested levels and enables, bit order supply, second battery, first battery, adapter
	input  wire logic [3:0] lvl,
	input  wire logic [3:0] en,
	// Comparator outputs
	output logic [3:0]      cmp
);
	// A disabled comparator gives no valid result, so its output wanders every cycle.
	initial cmp = 4'h0;
	always @(posedge clk) begin
		cmp <= (en & lvl) | (~en & ~cmp);
	end
endmodule

`default_nettype wire
